// ==== common/cal_trim_pkg.sv ====
`default_nettype none
package cal_trim_pkg;
   // Printed offsets are not all multiples of four: index, byte address = 4 * index
   localparam logic [7:0]  IDX_CAL_EN     = 8'h70;
   localparam logic [7:0]  IDX_CAL_PORT   = 8'h71;
   localparam logic [7:0]  IDX_GAIN_A     = 8'h7a;
   localparam logic [7:0]  IDX_GAIN_B     = 8'h7b;
   localparam logic [7:0]  IDX_REF        = 8'h7c;
   localparam logic [7:0]  IDX_TERM_A     = 8'h7e;
   localparam logic [7:0]  IDX_TERM_B     = 8'h7f;
   localparam logic [7:0]  IDX_TADJ_FIRST = 8'h80;
   localparam int          TADJ_COUNT     = 6;
   localparam logic [7:0]  IDX_STATUS     = 8'h90;
   localparam int          CAL_EN_BIT     = 0;
   localparam int          ST_HALTED_BIT  = 0;
   localparam int          ST_DONE_BIT    = 1;
   localparam int          ST_ABORT_BIT   = 2;
   localparam int          REF_CODE_MSB   = 3;
   localparam logic [7:0]  CAL_EN_RESET   = 8'h00;
   localparam logic [3:0]  REF_RSVD_RESET = 4'h0;
   localparam int          CAL_LEN        = 673;
   localparam int          PTR_W          = 10;
   localparam logic [9:0]  CAL_LAST       = 10'(CAL_LEN - 1);

   typedef struct packed {
      logic [7:0] gain_a;
      logic [7:0] gain_b;
      logic [7:0] ref_code;
      logic [7:0] term_a;
      logic [7:0] term_b;
      logic [TADJ_COUNT*8-1:0] tadj;
   } trim_set_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] wdata;
   } cal_req_t;

   typedef struct packed {
      logic       halted;
      logic [7:0] rdata;
   } cal_rsp_t;
endpackage
`default_nettype wire

// ==== hw/cal_vector_pointer.sv ====
`timescale 1ns/10ps
`default_nettype none
module cal_vector_pointer #(
   parameter int LEN = 673,
   parameter int W   = 10
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         restart,
   input  wire logic         step,
   output logic [W-1:0]      ptr,
   output logic              wrapped,
   output logic              busy
);
   typedef struct packed {
      logic [W-1:0] ptr;
      logic         wrapped;
      logic         busy;
   } ptr_state_t;

   ptr_state_t st;
   ptr_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.wrapped = 1'b0;
      if (restart) begin
         next_st.ptr  = '0;
         next_st.busy = 1'b0;
      end else if (step) begin
         if (st.ptr == W'(LEN - 1)) begin
            next_st.ptr     = '0;
            next_st.wrapped = 1'b1;
            next_st.busy    = 1'b0;
         end else begin
            next_st.ptr  = st.ptr + W'(1);
            next_st.busy = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ptr     = st.ptr;
   assign wrapped = st.wrapped;
   assign busy    = st.busy;
endmodule
`default_nettype wire

// ==== hw/adc_cal_vector_trim_regs.sv ====
// Operation
// - Enable bit gates vector port read/write pulses and pointer steps; port reads return cal_rsp.rdata even while disabled
// - Each read returns next vector byte
// - Each write loads next vector byte
// - Channel A gain trim, 8-bit read/write
// - Channel B gain trim, 8-bit read/write
// - Reference trim low nibble, reserved high nibble zeroed at factory load only, writes store all 8 bits
// - Input A termination trim, 8-bit
// - Input B termination trim, 8-bit
// - Trims reset to factory, then overwritable
// - Per-core timing adjust, factory loaded
`timescale 1ns/10ps
`default_nettype none
module adc_cal_vector_trim_regs
   import cal_trim_pkg::*;
#(
   parameter cal_trim_pkg::trim_set_t FACTORY = '0
) (
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic [31:0]                 hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   output cal_trim_pkg::cal_req_t      cal_req,
   input  wire cal_trim_pkg::cal_rsp_t cal_rsp,
   output cal_trim_pkg::trim_set_t     trims,
   output logic                        cal_enable
);
   import cal_trim_pkg::*;

   typedef struct packed {
      logic       ph_valid;
      logic       ph_write;
      logic [7:0] ph_index;
      logic       rd_pend;
      logic [7:0] cal_en;
      trim_set_t  trim;
      logic       loaded;
      logic       halted_s1;
      logic       halted_s2;
      logic       seq_done;
      logic       seq_abort;
      cal_req_t   req;
      logic [31:0] rdata;
   } regs_state_t;

   regs_state_t st;
   regs_state_t next_st;
   logic [PTR_W-1:0] ptr;
   logic             wrapped;
   logic             busy;
   logic             port_rd;
   logic             port_wr;
   logic             en_rise;

   // Bus phases: address phase latched, data phase always zero wait
   wire addr_ok = hsel && hready && htrans[1];
   wire [7:0] a_idx = (haddr[31:10] == '0) ? haddr[9:2] : 8'hff;
   wire [7:0] d_idx = st.ph_index;
   wire [7:0] byte_w = hwdata[7:0];
   wire port_hit = st.ph_valid && (d_idx == IDX_CAL_PORT);

   assign port_rd = port_hit && !st.ph_write && st.cal_en[CAL_EN_BIT];
   assign port_wr = port_hit && st.ph_write && st.cal_en[CAL_EN_BIT];
   assign en_rise = st.ph_valid && st.ph_write && d_idx == IDX_CAL_EN
                    && byte_w[CAL_EN_BIT] && !st.cal_en[CAL_EN_BIT];

   cal_vector_pointer #(
      .LEN (CAL_LEN),
      .W   (PTR_W)
   ) u_ptr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .restart (en_rise),
      .step    (port_rd || port_wr),
      .ptr     (ptr),
      .wrapped (wrapped),
      .busy    (busy)
   );

   function automatic logic [7:0] read_mux(input regs_state_t s, input logic [7:0] idx,
                                           input logic [PTR_W-1:0] p, input logic b);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         IDX_CAL_EN: v = s.cal_en;
         IDX_GAIN_A: v = s.trim.gain_a;
         IDX_GAIN_B: v = s.trim.gain_b;
         IDX_REF:    v = s.trim.ref_code;
         IDX_TERM_A: v = s.trim.term_a;
         IDX_TERM_B: v = s.trim.term_b;
         IDX_STATUS: v = {5'h00, s.seq_abort, s.seq_done, s.halted_s2};
         default: begin
            if (idx >= IDX_TADJ_FIRST && idx < IDX_TADJ_FIRST + 8'(TADJ_COUNT))
               v = s.trim.tadj[8*(idx - IDX_TADJ_FIRST) +: 8];
         end
      endcase
      if (p == p && b == b) v = v;
      return v;
   endfunction

   always_comb begin
      next_st = st;
      next_st.req.rd = 1'b0;
      next_st.req.wr = 1'b0;
      next_st.halted_s1 = cal_rsp.halted;
      next_st.halted_s2 = st.halted_s1;
      // Factory codes loaded on the first edge after reset
      if (!st.loaded) begin
         next_st.trim   = FACTORY;
         next_st.trim.ref_code[7:REF_CODE_MSB+1] = REF_RSVD_RESET;
         next_st.loaded = 1'b1;
      end
      if (st.ph_valid && st.ph_write) begin
         case (d_idx)
            IDX_CAL_EN: begin
               next_st.cal_en = byte_w;
               if (en_rise) begin
                  next_st.seq_done  = 1'b0;
                  next_st.seq_abort = 1'b0;
               end
               if (!byte_w[CAL_EN_BIT] && busy)
                  next_st.seq_abort = 1'b1;
            end
            IDX_CAL_PORT: begin
               next_st.req.wr    = port_wr;
               next_st.req.wdata = byte_w;
            end
            IDX_GAIN_A: next_st.trim.gain_a   = byte_w;
            IDX_GAIN_B: next_st.trim.gain_b   = byte_w;
            IDX_REF:    next_st.trim.ref_code = byte_w;
            IDX_TERM_A: next_st.trim.term_a   = byte_w;
            IDX_TERM_B: next_st.trim.term_b   = byte_w;
            default: begin
               if (d_idx >= IDX_TADJ_FIRST && d_idx < IDX_TADJ_FIRST + 8'(TADJ_COUNT))
                  next_st.trim.tadj[8*(d_idx - IDX_TADJ_FIRST) +: 8] = byte_w;
            end
         endcase
      end
      if (port_rd)
         next_st.req.rd = 1'b1;
      if (wrapped)
         next_st.seq_done = 1'b1;
      // Read data for the following data phase
      next_st.rdata = '0;
      if (addr_ok && !hwrite) begin
         if (a_idx == IDX_CAL_PORT)
            next_st.rdata = {24'h0, cal_rsp.rdata};
         else
            next_st.rdata = {24'h0, read_mux(st, a_idx, ptr, busy)};
      end
      next_st.ph_valid = addr_ok;
      next_st.ph_write = hwrite;
      next_st.ph_index = a_idx;
      next_st.rd_pend  = addr_ok && !hwrite;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st        <= '0;
         st.cal_en <= CAL_EN_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata     = st.rdata;
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign cal_req    = st.req;
   assign trims      = st.trim;
   assign cal_enable = st.cal_en[CAL_EN_BIT];

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence port_write_s;
      st.ph_valid && st.ph_write && d_idx == IDX_CAL_PORT;
   endsequence

   gate_off_a: assert property (port_hit && !st.cal_en[CAL_EN_BIT]
      |=> !cal_req.rd && !cal_req.wr) else $error("Port access while disabled");
   read_step_a: assert property (port_rd |=> cal_req.rd)
      else $error("Vector read not forwarded");
   write_step_a: assert property (port_write_s and st.cal_en[CAL_EN_BIT]
      |=> cal_req.wr && cal_req.wdata == $past(hwdata[7:0]))
      else $error("Vector write not forwarded");
   ptr_restart_a: assert property (en_rise |=> ptr == '0)
      else $error("Pointer not restarted");
   ptr_wrap_a: assert property ((port_rd || port_wr) && ptr == CAL_LAST
      |=> ptr == '0 ##1 st.seq_done) else $error("Pointer wrap wrong");
   ref_rsvd_a: assert property (st.loaded && $past(st.loaded)
      && !$past(st.ph_valid) |-> $stable(trims.ref_code))
      else $error("Reference trim changed without write");
   gain_wr_a: assert property (st.loaded && st.ph_valid && st.ph_write
      && d_idx == IDX_GAIN_A |=> trims.gain_a == $past(hwdata[7:0]))
      else $error("Gain A write lost");
   term_wr_a: assert property (st.loaded && st.ph_valid && st.ph_write
      && d_idx == IDX_TERM_B |=> trims.term_b == $past(hwdata[7:0]))
      else $error("Termination B write lost");
   factory_a: assert property ($rose(st.loaded) |-> trims.gain_b
      == FACTORY.gain_b) else $error("Factory code missing");
   ready_a: assert property (hreadyout && !hresp)
      else $error("Slave not ready");

   // Trim register writes, enable, pointer, status and read data checks
   sequence trim_write_s(logic [7:0] idx);
      st.loaded && st.ph_valid && st.ph_write && d_idx == idx;
   endsequence

   sequence en_write_s;
      st.ph_valid && st.ph_write && d_idx == IDX_CAL_EN;
   endsequence

   gain_b_wr_a: assert property (trim_write_s(IDX_GAIN_B)
      |=> trims.gain_b == $past(hwdata[7:0])) else $error("Gain B write lost");
   ref_wr_a: assert property (trim_write_s(IDX_REF)
      |=> trims.ref_code == $past(hwdata[7:0])) else $error("Reference write lost");
   term_a_wr_a: assert property (trim_write_s(IDX_TERM_A)
      |=> trims.term_a == $past(hwdata[7:0])) else $error("Termination A write lost");
   tadj_first_a: assert property (trim_write_s(IDX_TADJ_FIRST)
      |=> trims.tadj[7:0] == $past(hwdata[7:0])) else $error("Timing adjust write lost");
   tadj_last_a: assert property (trim_write_s(IDX_TADJ_FIRST + 8'(TADJ_COUNT - 1))
      |=> trims.tadj[TADJ_COUNT*8-1 -: 8] == $past(hwdata[7:0]))
      else $error("Last timing adjust write lost");
   ref_load_a: assert property ($rose(st.loaded)
      |-> trims.ref_code[7:REF_CODE_MSB+1] == REF_RSVD_RESET)
      else $error("Reserved reference bits not cleared");
   factory_all_a: assert property ($rose(st.loaded)
      |-> trims.gain_a == FACTORY.gain_a && trims.term_a == FACTORY.term_a
      && trims.term_b == FACTORY.term_b && trims.tadj == FACTORY.tadj)
      else $error("Factory trim set missing");
   en_write_a: assert property (en_write_s
      |=> cal_enable == $past(hwdata[CAL_EN_BIT])) else $error("Enable write lost");
   ptr_hold_a: assert property (port_hit && !st.cal_en[CAL_EN_BIT]
      |=> $stable(ptr)) else $error("Pointer moved while disabled");
   ptr_step_a: assert property (port_rd && ptr != CAL_LAST
      |=> ptr == $past(ptr) + 10'h001) else $error("Pointer did not step");
   done_set_a: assert property (wrapped |=> st.seq_done)
      else $error("Sequence done not set");
   abort_set_a: assert property (en_write_s and !byte_w[CAL_EN_BIT] && busy
      |=> st.seq_abort) else $error("Abort not flagged");
   restart_clr_a: assert property (en_rise && !wrapped
      |=> !st.seq_done && !st.seq_abort) else $error("Status not cleared on enable");
   halted_sync_a: assert property (st.loaded && $past(st.loaded)
      |-> st.halted_s2 == $past(cal_rsp.halted, 2)) else $error("Halted sync wrong");
   rd_idle_a: assert property (!st.rd_pend |-> hrdata == 32'h0000_0000)
      else $error("Read data outside read phase");
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import cal_trim_pkg::*;
   localparam trim_set_t FAC = {8'h5a, 8'hc3, 8'hf6, 8'h81, 8'h7e, 48'h1122_3344_5566};
   localparam logic [7:0] TBL [5] = '{IDX_GAIN_A, IDX_GAIN_B, IDX_REF, IDX_TERM_A, IDX_TERM_B};
   logic        hclk      = 1'b0;
   logic        hresetn   = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'b0;
   logic [31:0] hwdata    = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   cal_req_t    cal_req;
   cal_rsp_t    cal_rsp   = 9'h100;
   trim_set_t   trims;
   trim_set_t   shadow;
   logic        cal_enable;
   logic        rd_dphase = 1'b0;
   logic [31:0] seed      = 32'ha8ff9b9d;
   logic [7:0]  rq[$];
   logic [7:0]  wq[$];
   int          bad_count = 0;
   int          cmp_count = 0;
   int          rd_seen   = 0;
   int          wr_seen   = 0;
   int          cycles    = 0;

   adc_cal_vector_trim_regs #(.FACTORY(FAC)) u_adc_cal_vector_trim_regs (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cal_req(cal_req),
      .cal_rsp(cal_rsp), .trims(trims), .cal_enable(cal_enable));

   initial forever #20 hclk = ~hclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] idx_of(input int i);
      return (i < 5) ? TBL[i] : 8'(IDX_TADJ_FIRST + i - 5);
   endfunction
   function automatic int pos(input int i);
      return (i < 5) ? 80 - 8 * i : 8 * (i - 5);
   endfunction

   task automatic chk(input string nm, input logic [87:0] e, input logic [87:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic close_out;
      if (bad_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One AHB single transfer, address phase then data phase
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      htrans <= 2'h2;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans    <= 2'h0;
      hwdata    <= {24'h0, d};
      rd_dphase <= ~w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_dphase <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      rq.push_back(e);
      bus(1'b0, idx, 8'h00);
   endtask
   task automatic prd;
      seed = lfsr(seed);
      cal_rsp.rdata <= seed[7:0];
      rd(IDX_CAL_PORT, seed[7:0]);
   endtask
   task automatic pwr(input logic en);
      seed = lfsr(seed);
      if (en) wq.push_back(seed[7:0]);
      bus(1'b1, IDX_CAL_PORT, seed[7:0]);
   endtask

   // Result watcher: oldest note against what appears
   always @(posedge hclk) begin
      cycles++;
      if (rd_dphase && hreadyout === 1'b1) begin
         chk("hrdata", rq.size() ? rq.pop_front() : 8'hxx, hrdata[7:0]);
         chk("hresp", 1'b0, hresp);
      end
      if (hresetn && cal_req.wr === 1'b1) begin
         wr_seen++;
         chk("cal_wdata", wq.size() ? wq.pop_front() : 8'hxx, cal_req.wdata);
      end
      if (hresetn && cal_req.rd === 1'b1) rd_seen++;
      if (cycles > 12000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      shadow = FAC;
      shadow.ref_code[7:4] = REF_RSVD_RESET;
      chk("trims", shadow, trims);
      rd(IDX_CAL_EN, CAL_EN_RESET);
      for (int i = 0; i < 11; i++) rd(idx_of(i), shadow[pos(i) +: 8]);
      for (int i = 0; i < 11; i++) begin
         seed = lfsr(seed);
         bus(1'b1, idx_of(i), seed[7:0]);
         shadow[pos(i) +: 8] = seed[7:0];
      end
      for (int i = 0; i < 11; i++) rd(idx_of(i), shadow[pos(i) +: 8]);
      chk("trims", shadow, trims);
      bus(1'b1, 8'h7d, 8'hff);
      rd(8'h7d, 8'h00);
      pwr(1'b0);
      prd();
      repeat (3) @(posedge hclk);
      chk("pulses", 0, rd_seen + wr_seen);
      bus(1'b1, IDX_CAL_EN, 8'h01);
      rd(IDX_CAL_EN, 8'h01);
      chk("cal_enable", 1'b1, cal_enable);
      repeat (CAL_LEN - 1) prd();
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, 8'h01);
      prd();
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, 8'h03);
      chk("rd_seen", CAL_LEN, rd_seen);
      bus(1'b1, IDX_CAL_EN, 8'h00);
      bus(1'b1, IDX_CAL_EN, 8'h01);
      rd(IDX_STATUS, 8'h01);
      repeat (CAL_LEN - 1) pwr(1'b1);
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, 8'h01);
      pwr(1'b1);
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, 8'h03);
      chk("wr_seen", CAL_LEN, wr_seen);
      bus(1'b1, IDX_CAL_EN, 8'h00);
      bus(1'b1, IDX_CAL_EN, 8'h01);
      repeat (5) pwr(1'b1);
      bus(1'b1, IDX_CAL_EN, 8'h00);
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, 8'h05);
      bus(1'b1, IDX_CAL_EN, 8'h01);
      rd(IDX_STATUS, 8'h01);
      repeat (3) @(posedge hclk);
      chk("wr_seen", CAL_LEN + 5, wr_seen);
      close_out();
   end
endmodule
`default_nettype wire
